// ===== core/lrs_defs.svh
`ifndef LRS_DEFS_SVH
`define LRS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LRS_CTRL_OFS 4'h0
`define LRS_STATUS_OFS 4'h4
`define LRS_CFG_IDX_OFS 4'h8
`define LRS_CFG_DATA_OFS 4'hc

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define LRS_CTRL_MODE_MSB 3
`define LRS_CTRL_WESRC_BIT 4
`define LRS_MODE_MAX 4'hb
`define LRS_CTRL_RST 32'h0000_0000
`define LRS_CFG_IDX_RST 8'h00

// ----------------------------------------------------------------
// Table geometry
// ----------------------------------------------------------------
`define LRS_TABLES 4
`define LRS_TAB_DEPTH 64
`define LRS_SRL_LEN 32
`define LRS_SRL_HALF 16

`endif

// ===== core/lrs_pkg.sv
package lrs_pkg;

  // Slice operating modes
  typedef enum logic [3:0] {
    M_RAM_SP64,
    M_RAM_DP64,
    M_RAM_SP128,
    M_RAM_DP128,
    M_RAM_SP256,
    M_ROM64,
    M_ROM128,
    M_ROM256,
    M_SRL32,
    M_SRL_CHAIN,
    M_SRL16X2,
    M_MUX
  } lrs_mode_t;

  // Avalon-MM request group
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } lrs_avs_req_t;

  // Four tables of 64 bits each
  typedef logic [3:0][63:0] lrs_mem_t;

  // Control and bus state
  typedef struct packed {
    lrs_mode_t mode;
    logic we_src;
    logic [7:0] cfg_idx;
    logic ack;
    logic [31:0] rdata;
    logic [3:0] reg_read;
  } lrs_state_t;

endpackage

// ===== core/lrs_slice.sv
`timescale 1ns/1ns
`include "lrs_defs.svh"
// Summary of operation
// - RAM write on one clock edge, only while the selected strobe (write enable, or clock enable when we_src is set) is high.
// - Primary output reads shared address; second output reads read-only address.
// - RAM outputs follow address combinationally, no clock involved.
// - Two 64-deep dual or 128-deep single RAMs share slice controls.
// - RAM deeper than 64 uses combiners steered by upper address bits.
// - Each table is a 64-entry ROM; 128 uses two, 256 uses four.
// - ROM contents come from configuration only, never written in operation.
// - A table is a shift register of 1 to 32 cycles delay.
// - Four tables chain last bit to next shift input, up to 128.
// - Chain plus combiners give addressable 128-bit shift register.
// - Only the first table exposes its cascade output.
// - With clock enable high, data enters bit zero, all bits move up.
// - Cascade output carries the top bit, changing only after a shift.
// - Five-bit read address selects any of 32 stored bits.
// - No reset touches the shift register contents.
// - Shift output follows read address combinationally, ignoring clock enable.
// - Fixed read address N gives length N+1, output changes per shift.
// - Registered read through slice flip-flop adds exactly one cycle.
// - One table holds two independent 16-bit shift registers.
// - Each table forms a 4:1 selector; four per slice, registerable.
// - Two pair combiners each form an 8:1 selector.
// - Quad combiner forms one 16:1 selector per slice.
// - Dual-port second table reads at read-only address, writes shared.
module lrs_slice import lrs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire lrs_avs_req_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic write_enable_i,
  input wire logic clock_enable_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] second_read_address_i,
  input wire logic [3:0] data_i,
  input wire logic serial_shift_in_i,
  input wire logic [15:0] mux_data_i,
  input wire logic [3:0] mux_sel_i,
  output logic [3:0] primary_read_output_o,
  output logic [1:0] second_read_output_o,
  output logic [3:0] table_main_output_o,
  output logic lower_pair_combiner_o,
  output logic upper_pair_combiner_o,
  output logic quad_combiner_o,
  output logic cascade_shift_out_o,
  output logic [3:0] registered_read_o
);

  lrs_state_t st_q;
  lrs_state_t st_d;
  lrs_mem_t mem_q;
  lrs_mem_t mem_d;
  logic [3:0][5:0] tidx;
  logic [3:0] tab_o;
  logic lsel;
  logic usel;
  logic qsel;
  logic lo_c;
  logic up_c;
  logic qd_c;
  logic [3:0] primary_read_output;
  logic [1:0] second_read_output;
  logic req;
  logic bus_wr;
  logic cfg_wr;
  logic ram_wen;
  logic [6:0] chain_pos;

  // ----------------------------------------------------------------
  // Bus handshake and write sources
  // ----------------------------------------------------------------
  assign req = avs_req_i.read | avs_req_i.write;
  assign avs_waitrequest_o = req & ~st_q.ack;
  assign avs_readdata_o = st_q.rdata;
  assign bus_wr = avs_req_i.write & st_q.ack & avs_req_i.byteenable[0];
  assign cfg_wr = bus_wr & (avs_req_i.address == `LRS_CFG_DATA_OFS);
  assign ram_wen = st_q.we_src ? clock_enable_i : write_enable_i;
  assign chain_pos = addr_i[6:0];

  // ----------------------------------------------------------------
  // Table reads and combiners
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < `LRS_TABLES; k++) begin
      tidx[k] = addr_i[5:0];
    end
    lsel = 1'b0;
    usel = 1'b0;
    qsel = 1'b0;
    unique case (st_q.mode)
      M_RAM_DP64: begin
        tidx[1] = second_read_address_i[5:0];
        tidx[3] = second_read_address_i[5:0];
      end
      M_RAM_SP128, M_ROM128: begin
        lsel = addr_i[6];
        usel = addr_i[6];
      end
      M_RAM_DP128: begin
        tidx[2] = second_read_address_i[5:0];
        tidx[3] = second_read_address_i[5:0];
        lsel = addr_i[6];
        usel = second_read_address_i[6];
      end
      M_RAM_SP256, M_ROM256: begin
        lsel = addr_i[6];
        usel = addr_i[6];
        qsel = addr_i[7];
      end
      M_SRL32: begin
        for (int k = 0; k < `LRS_TABLES; k++) begin
          tidx[k] = {1'b0, addr_i[4:0]};
        end
      end
      M_SRL_CHAIN: begin
        for (int k = 0; k < `LRS_TABLES; k++) begin
          tidx[k] = {1'b0, chain_pos[4:0]};
        end
        lsel = ~chain_pos[5];
        usel = ~chain_pos[5];
        qsel = ~chain_pos[6];
      end
      M_MUX: begin
        lsel = mux_sel_i[2];
        usel = mux_sel_i[2];
        qsel = mux_sel_i[3];
      end
      default: begin
      end
    endcase
    for (int k = 0; k < `LRS_TABLES; k++) begin
      tab_o[k] = mem_q[k][tidx[k]];
    end
    if (st_q.mode == M_MUX) begin
      for (int k = 0; k < `LRS_TABLES; k++) begin
        tab_o[k] = mux_data_i[4 * k + int'(mux_sel_i[1:0])];
      end
    end
    if (st_q.mode == M_SRL16X2) begin
      tab_o[0] = mem_q[0][{2'b00, addr_i[3:0]}];
      tab_o[1] = mem_q[0][{2'b01, addr_i[3:0]}];
      tab_o[2] = mem_q[1][{2'b00, addr_i[3:0]}];
      tab_o[3] = mem_q[1][{2'b01, addr_i[3:0]}];
    end
    lo_c = lsel ? tab_o[1] : tab_o[0];
    up_c = usel ? tab_o[3] : tab_o[2];
    qd_c = qsel ? up_c : lo_c;
    primary_read_output = tab_o;
    second_read_output = 2'b00;
    unique case (st_q.mode)
      M_RAM_DP64: begin
        primary_read_output = {2'b00, tab_o[2], tab_o[0]};
        second_read_output = {tab_o[3], tab_o[1]};
      end
      M_RAM_SP128, M_ROM128: begin
        primary_read_output = {2'b00, up_c, lo_c};
      end
      M_RAM_DP128: begin
        primary_read_output = {3'b000, lo_c};
        second_read_output = {1'b0, up_c};
      end
      M_RAM_SP256, M_ROM256, M_SRL_CHAIN: begin
        primary_read_output = {3'b000, qd_c};
      end
      default: begin
      end
    endcase
  end

  assign primary_read_output_o = primary_read_output;
  assign second_read_output_o = second_read_output;
  assign table_main_output_o = tab_o;
  assign lower_pair_combiner_o = lo_c;
  assign upper_pair_combiner_o = up_c;
  assign quad_combiner_o = qd_c;
  // Only table 0 drives the cascade pin
  assign cascade_shift_out_o = ((st_q.mode == M_SRL32) ||
    (st_q.mode == M_SRL_CHAIN)) ? mem_q[0][31] : 1'b0;
  assign registered_read_o = st_q.reg_read;

  // ----------------------------------------------------------------
  // Next state: bus, writes and shifts
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    mem_d = mem_q;
    st_d.ack = req & ~st_q.ack;
    st_d.reg_read = primary_read_output;
    if (st_d.ack && avs_req_i.read) begin
      unique case (avs_req_i.address)
        `LRS_CTRL_OFS: st_d.rdata = {27'h0, st_q.we_src, st_q.mode};
        `LRS_STATUS_OFS: st_d.rdata = {24'h0, qd_c, cascade_shift_out_o,
          second_read_output, primary_read_output};
        `LRS_CFG_IDX_OFS: st_d.rdata = {24'h0, st_q.cfg_idx};
        `LRS_CFG_DATA_OFS: st_d.rdata = {31'h0,
          mem_q[st_q.cfg_idx[7:6]][st_q.cfg_idx[5:0]]};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    if (bus_wr && avs_req_i.address == `LRS_CTRL_OFS) begin
      if (avs_req_i.writedata[`LRS_CTRL_MODE_MSB:0] <= `LRS_MODE_MAX) begin
        st_d.mode = lrs_mode_t'(avs_req_i.writedata[`LRS_CTRL_MODE_MSB:0]);
      end
      st_d.we_src = avs_req_i.writedata[`LRS_CTRL_WESRC_BIT];
    end
    if (bus_wr && avs_req_i.address == `LRS_CFG_IDX_OFS) begin
      st_d.cfg_idx = avs_req_i.writedata[7:0];
    end
    if (cfg_wr) begin
      st_d.cfg_idx = st_q.cfg_idx + 8'h01;
    end
    unique case (st_q.mode)
      M_RAM_SP64: begin
        if (ram_wen) begin
          for (int k = 0; k < `LRS_TABLES; k++) begin
            mem_d[k][addr_i[5:0]] = data_i[k];
          end
        end
      end
      M_RAM_DP64: begin
        if (ram_wen) begin
          mem_d[0][addr_i[5:0]] = data_i[0];
          mem_d[1][addr_i[5:0]] = data_i[0];
          mem_d[2][addr_i[5:0]] = data_i[1];
          mem_d[3][addr_i[5:0]] = data_i[1];
        end
      end
      M_RAM_SP128: begin
        if (ram_wen) begin
          mem_d[{1'b0, addr_i[6]}][addr_i[5:0]] = data_i[0];
          mem_d[{1'b1, addr_i[6]}][addr_i[5:0]] = data_i[1];
        end
      end
      M_RAM_DP128: begin
        if (ram_wen) begin
          mem_d[{1'b0, addr_i[6]}][addr_i[5:0]] = data_i[0];
          mem_d[{1'b1, addr_i[6]}][addr_i[5:0]] = data_i[0];
        end
      end
      M_RAM_SP256: begin
        if (ram_wen) begin
          mem_d[addr_i[7:6]][addr_i[5:0]] = data_i[0];
        end
      end
      M_SRL32: begin
        if (clock_enable_i) begin
          for (int k = 0; k < `LRS_TABLES; k++) begin
            mem_d[k][31:0] = {mem_q[k][30:0], data_i[k]};
          end
        end
      end
      M_SRL_CHAIN: begin
        if (clock_enable_i) begin
          mem_d[3][31:0] = {mem_q[3][30:0], serial_shift_in_i};
          for (int k = 0; k < `LRS_TABLES - 1; k++) begin
            mem_d[k][31:0] = {mem_q[k][30:0], mem_q[k + 1][31]};
          end
        end
      end
      M_SRL16X2: begin
        if (clock_enable_i) begin
          for (int k = 0; k < 2; k++) begin
            mem_d[k][15:0] = {mem_q[k][14:0], data_i[2 * k]};
            mem_d[k][31:16] = {mem_q[k][30:16], data_i[2 * k + 1]};
          end
        end
      end
      default: begin
      end
    endcase
    // Configuration load overrides a same-cycle user write
    if (cfg_wr) begin
      mem_d[st_q.cfg_idx[7:6]][st_q.cfg_idx[5:0]] =
        avs_req_i.writedata[0];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Table contents have no reset path
  always_ff @(posedge clk_i) begin
    mem_q <= mem_d;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  ram_write_a: assert property ((st_q.mode == M_RAM_SP64) && ram_wen &&
    !cfg_wr |=> mem_q[2][$past(addr_i[5:0])] == $past(data_i[2]))
    else $error("ram write lost");

  ram_hold_a: assert property ((st_q.mode == M_RAM_SP64) && !ram_wen &&
    !cfg_wr |=> $stable(mem_q))
    else $error("ram changed without write");

  dual_read_a: assert property ((st_q.mode == M_RAM_DP64) |->
    (second_read_output_o[0] == mem_q[1][second_read_address_i[5:0]]) &&
    (primary_read_output_o[1] == mem_q[2][addr_i[5:0]]))
    else $error("dual port read mismatch");

  rom_locked_a: assert property ((st_q.mode inside {M_ROM64, M_ROM128,
    M_ROM256}) && !cfg_wr &&
    (write_enable_i || clock_enable_i) |=> $stable(mem_q))
    else $error("rom written in operation");

  srl_shift_a: assert property ((st_q.mode == M_SRL32) && clock_enable_i &&
    !cfg_wr |=> (mem_q[1][0] == $past(data_i[1])) &&
    (mem_q[1][31:1] == $past(mem_q[1][30:0])))
    else $error("shift step wrong");

  chain_cascade_a: assert property ((st_q.mode == M_SRL_CHAIN) &&
    clock_enable_i && !cfg_wr |=>
    cascade_shift_out_o == $past(mem_q[0][30]))
    else $error("cascade output wrong");

  static_len_a: assert property ((st_q.mode == M_SRL32) &&
    (addr_i[4:0] == 5'h02) && !cfg_wr && clock_enable_i
    ##1 clock_enable_i && !cfg_wr ##1 clock_enable_i && !cfg_wr
    ##1 (addr_i[4:0] == 5'h02) && (st_q.mode == M_SRL32) |->
    primary_read_output_o[0] == $past(data_i[0], 3))
    else $error("static length not N plus one");

  reg_read_a: assert property ($past(rst_b_i) |->
    registered_read_o === $past(primary_read_output_o))
    else $error("registered read latency wrong");

  quad_mux_a: assert property ((st_q.mode == M_MUX) |->
    quad_combiner_o == mux_data_i[mux_sel_i])
    else $error("16 to 1 select wrong");

  pair_mux_a: assert property ((st_q.mode == M_MUX) |->
    upper_pair_combiner_o == mux_data_i[{1'b1, mux_sel_i[2:0]}])
    else $error("8 to 1 select wrong");

  bus_answer_a: assert property (req && avs_waitrequest_o |=>
    !avs_waitrequest_o)
    else $error("bus answer late");

  chain_read_a: assert property ((st_q.mode == M_SRL_CHAIN) |->
    primary_read_output_o[0] ==
    mem_q[~addr_i[6:5]][addr_i[4:0]])
    else $error("chain position read wrong");

  casc_quiet_a: assert property (!((st_q.mode == M_SRL32) ||
    (st_q.mode == M_SRL_CHAIN)) |-> !cascade_shift_out_o)
    else $error("cascade output active");

  half_shift_a: assert property ((st_q.mode == M_SRL16X2) &&
    clock_enable_i && !cfg_wr |=> (mem_q[1][16] == $past(data_i[3])) &&
    (mem_q[1][15:1] == $past(mem_q[1][14:0])))
    else $error("dual 16 shift wrong");

  deep_read_a: assert property ((st_q.mode == M_RAM_SP256) |->
    primary_read_output_o[0] == mem_q[addr_i[7:6]][addr_i[5:0]])
    else $error("256 deep read wrong");

endmodule // lrs_slice

// ===== tb/lrs_user_model.sv
`timescale 1ns/1ns
module lrs_user_model (
  input wire logic clk_i,
  output logic write_enable_o,
  output logic clock_enable_o,
  output logic [7:0] addr_o,
  output logic [7:0] second_addr_o,
  output logic [3:0] data_o,
  output logic shift_in_o
);
  // ----------------------------------------------------------------
  // User traffic, one cycle per call, launched after an edge
  // ----------------------------------------------------------------
  initial begin
    write_enable_o = 1'b0;
    clock_enable_o = 1'b0;
    addr_o = 8'h00;
    second_addr_o = 8'h00;
    data_o = 4'h0;
    shift_in_o = 1'b0;
  end

  task automatic put(input logic we, input logic ce, input logic [7:0] a,
                     input logic [7:0] b, input logic [3:0] d,
                     input logic srl);
    @(posedge clk_i);
    write_enable_o <= we;
    clock_enable_o <= ce;
    addr_o <= srl ? (a | 8'h20) : a;
    second_addr_o <= b;
    data_o <= d;
    shift_in_o <= d[0];
  endtask
endmodule // lrs_user_model

// ===== tb/test_lrs_slice.sv
`timescale 1ns/1ns
`include "lrs_defs.svh"
module test_lrs_slice import lrs_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  lrs_avs_req_t req = '0;
  logic [31:0] rdata, rd, r, sr;
  logic wait_r, we, ce, sin, lo_c, up_c, q_c, casc;
  logic [7:0] addr, addr2;
  logic [3:0] din, pro, tmo, rr, d, prev;
  logic [1:0] sro;
  logic [15:0] mdat = 16'h0000;
  logic [3:0] msel = 4'h0;
  logic [5:0] a, b;
  logic [63:0] mem [4];
  logic [1:0] dm [64];
  logic [1:0] m2 [128];
  logic [15:0] h16 [4];
  logic [127:0] c128;
  logic [255:0] m256;
  logic wr;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 35605;
  int i;

  always #5 clk_i = ~clk_i;

  lrs_user_model i_user (.clk_i(clk_i), .write_enable_o(we),
    .clock_enable_o(ce), .addr_o(addr), .second_addr_o(addr2),
    .data_o(din), .shift_in_o(sin));

  lrs_slice i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_req_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
    .write_enable_i(we), .clock_enable_i(ce), .addr_i(addr),
    .second_read_address_i(addr2), .data_i(din),
    .serial_shift_in_i(sin), .mux_data_i(mdat), .mux_sel_i(msel),
    .primary_read_output_o(pro), .second_read_output_o(sro),
    .table_main_output_o(tmo), .lower_pair_combiner_o(lo_c),
    .upper_pair_combiner_o(up_c), .quad_combiner_o(q_c),
    .cascade_shift_out_o(casc), .registered_read_o(rr));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] exp_sp(input logic [5:0] x);
    return {mem[3][x], mem[2][x], mem[1][x], mem[0][x]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] ad,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    req <= '{read: ~wr, write: wr, address: ad, writedata: wd,
             byteenable: 4'hf};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    if (wait_r !== 1'b0) begin
      error_cnt++;
      $display("[FAIL] %0t bus timeout", $time);
      print_verdict();
    end
    rd = rdata;
    req <= '0;
  endtask

  task automatic mode(input lrs_mode_t m, input logic s);
    idle();
    bus(1'b1, `LRS_CTRL_OFS, {27'h0, s, m});
  endtask

  task automatic idle();
    i_user.put(1'b0, 1'b0, 8'h00, 8'h00, 4'h0, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    mode(M_RAM_SP64, 1'b0);
    for (i = 0; i < 64; i++) begin
      i_user.put(1'b1, 1'b0, 8'(i), 8'h00, 4'(i), 1'b0);
      for (int k = 0; k < 4; k++) mem[k][i] = i[k];
    end
    for (i = 0; i < 200; i++) begin
      r = $random(seed);
      a = r[5:0];
      d = r[15:12];
      i_user.put(r[16], 1'b0, {2'b0, a}, 8'h00, d, 1'b0);
      #1;
      chk(pro, exp_sp(a), "ram read");
      if (i > 0) chk(rr, prev, "registered read");
      prev = exp_sp(a);
      if (r[16]) for (int k = 0; k < 4; k++) mem[k][a] = d[k];
    end
    mode(M_RAM_SP64, 1'b1);
    d = ~exp_sp(6'd6);
    i_user.put(1'b1, 1'b0, 8'h05, 8'h00, ~exp_sp(6'd5), 1'b0);
    i_user.put(1'b0, 1'b1, 8'h06, 8'h00, d, 1'b0);
    i_user.put(1'b0, 1'b0, 8'h05, 8'h00, 4'h0, 1'b0);
    #1;
    chk(pro, exp_sp(6'd5), "we ignored");
    i_user.put(1'b0, 1'b0, 8'h06, 8'h00, 4'h0, 1'b0);
    #1;
    chk(pro, d, "ce writes");
    $display("single port ram test done");
    mode(M_RAM_DP64, 1'b0);
    for (i = 0; i < 64; i++) begin
      i_user.put(1'b1, 1'b0, 8'(i), 8'h00, 4'(i), 1'b0);
      dm[i] = 2'(i);
    end
    for (i = 0; i < 100; i++) begin
      r = $random(seed);
      a = r[5:0];
      b = r[11:6];
      i_user.put(r[16], 1'b0, {2'b0, a}, {2'b0, b}, r[15:12], 1'b0);
      #1;
      chk(pro[1:0], dm[a], "dp primary");
      chk(sro, dm[b], "dp second");
      if (r[16]) dm[a] = r[13:12];
    end
    idle();
    $display("dual port ram test done");
    mode(M_SRL32, 1'b0);
    for (i = 0; i < 32; i++) begin
      i_user.put(1'b0, 1'b1, 8'h00, 8'h00, {3'b0, i[0]}, 1'b1);
      sr = {sr[30:0], i[0]};
    end
    for (i = 0; i < 150; i++) begin
      r = $random(seed);
      i_user.put(1'b0, r[16], {3'b0, r[4:0]}, 8'h00, r[15:12], 1'b1);
      #1;
      chk(pro[0], sr[r[4:0]], "shift tap");
      chk(casc, sr[31], "cascade");
      if (r[16]) sr = {sr[30:0], r[12]};
    end
    idle();
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    mode(M_SRL32, 1'b0);
    i_user.put(1'b0, 1'b0, 8'h1f, 8'h00, 4'h0, 1'b1);
    #1;
    chk(pro[0], sr[31], "kept over reset");
    for (i = 0; i < 3; i++) begin
      i_user.put(1'b0, 1'b1, 8'h02, 8'h00, {3'b0, ~i[0]}, 1'b1);
      sr = {sr[30:0], ~i[0]};
    end
    i_user.put(1'b0, 1'b0, 8'h02, 8'h00, 4'h0, 1'b1);
    #1;
    chk(pro[0], sr[2], "static length");
    $display("shift register test done");
    mode(M_SRL_CHAIN, 1'b0);
    for (i = 0; i < 200; i++) begin
      r = $random(seed);
      if (i < 128) r[16] = 1'b1;
      i_user.put(1'b0, r[16], {1'b0, r[6:0]}, 8'h00, r[15:12], 1'b0);
      #1;
      if (i >= 128) begin
        chk(pro[0], c128[r[6:0]], "chain tap");
        chk(casc, c128[127], "chain cascade");
      end
      if (r[16]) c128 = {c128[126:0], r[12]};
    end
    mode(M_SRL16X2, 1'b0);
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      if (i < 16) r[16] = 1'b1;
      i_user.put(1'b0, r[16], {4'h0, r[3:0]}, 8'h00, r[15:12], 1'b1);
      #1;
      for (int k = 0; k < 4; k++) begin
        if (i >= 16) chk(pro[k], h16[k][r[3:0]], "dual 16");
        if (r[16]) h16[k] = {h16[k][14:0], r[12 + k]};
      end
    end
    $display("chain shift test done");
    for (int j = 0; j < 2; j++) begin
      mode(j ? M_RAM_DP128 : M_RAM_SP128, 1'b0);
      for (i = 0; i < 200; i++) begin
        r = $random(seed);
        if (j == 0 && i < 128) r[6:0] = 7'(i);
        wr = (j == 0 && i < 128) || r[31];
        i_user.put(wr, 1'b0, {1'b0, r[6:0]}, {1'b0, r[22:16]}, r[15:12],
          1'b0);
        #1;
        if (j || i >= 128) begin
          chk(pro[0], m2[r[6:0]][0], "ram 128 low");
          if (j) chk(sro[0], m2[r[22:16]][1], "ram 128 second");
          else chk(pro[1], m2[r[6:0]][1], "ram 128 high");
        end
        if (wr) m2[r[6:0]] = j ? {2{r[12]}} : r[13:12];
      end
    end
    mode(M_RAM_SP256, 1'b0);
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      if (i < 256) r[7:0] = 8'(i);
      wr = i < 256 || r[16];
      i_user.put(wr, 1'b0, r[7:0], 8'h00, r[15:12], 1'b0);
      #1;
      if (i >= 256) chk(pro[0], m256[r[7:0]], "ram 256");
      if (wr) m256[r[7:0]] = r[12];
    end
    $display("deep ram test done");
    mode(M_MUX, 1'b0);
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      @(posedge clk_i);
      mdat <= r[15:0];
      msel <= r[19:16];
      #1;
      for (int k = 0; k < 4; k++) chk(tmo[k], r[4*k+r[17:16]], "mux4");
      chk(lo_c, r[{1'b0, r[18:16]}], "mux8 low");
      chk(up_c, r[{1'b1, r[18:16]}], "mux8 high");
      chk(q_c, r[r[19:16]], "mux16");
    end
    $display("mux test done");
    bus(1'b1, `LRS_CFG_IDX_OFS, 32'h5);
    bus(1'b1, `LRS_CFG_DATA_OFS, 32'h1);
    bus(1'b1, `LRS_CFG_DATA_OFS, 32'h0);
    bus(1'b0, `LRS_CFG_IDX_OFS, 32'h0);
    chk(rd, 32'h7, "index step");
    mode(M_ROM64, 1'b0);
    bus(1'b1, `LRS_CTRL_OFS, 32'hc);
    bus(1'b1, 4'h2, 32'h1);
    bus(1'b0, `LRS_CTRL_OFS, 32'h0);
    chk(rd, {28'h0, M_ROM64}, "mode kept");
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0, "unmapped");
    i_user.put(1'b1, 1'b1, 8'h05, 8'h00, 4'h0, 1'b0);
    i_user.put(1'b0, 1'b0, 8'h05, 8'h00, 4'h0, 1'b0);
    #1;
    chk(tmo[0], 1'b1, "rom entry 5");
    i_user.put(1'b0, 1'b0, 8'h06, 8'h00, 4'h0, 1'b0);
    #1;
    chk(tmo[0], 1'b0, "rom entry 6");
    mode(M_ROM128, 1'b0);
    i_user.put(1'b1, 1'b1, 8'h05, 8'h00, 4'h0, 1'b0);
    #1;
    chk(pro[0], 1'b1, "rom 128");
    mode(M_ROM256, 1'b0);
    i_user.put(1'b1, 1'b1, 8'h06, 8'h00, 4'hf, 1'b0);
    i_user.put(1'b0, 1'b0, 8'h06, 8'h00, 4'h0, 1'b0);
    #1;
    chk(pro[0], 1'b0, "rom 256 kept");
    $display("rom test done");
    print_verdict();
  end
endmodule // test_lrs_slice
